// ### hw/smrt_trigger_regs.sv
//
// Contract
// - Writing 1 to diag trigger bit 7 queues the ignition fault register readout.
// - Diag trigger bits 6 and 5 queue half-bridge fault registers 1 and 0.
// - Diag trigger bits 4 down to 0 queue output fault registers 4..0.
// - Control trigger bits 3 down to 0 queue control registers 3..0.
// - Offset 007 bits 7 and 6 queue half-bridge setup registers 1 and 0.
// - Offset 007 bits 5 down to 0 queue output setup registers 5..0.
// - Offset 008 bits 7 and 6 queue engine-off-timer setup registers 1 and 0.
// - Offset 008 bits 5..0 queue sensor, operating, comms and ignition setup reads.
// - A written 0 queues nothing and changes nothing.
// - Several set bits are read out from most to least significant.
// - All trigger bits reset to 0.
// - While upstream halt is 1, no readout data is sent upstream.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps

`include "smrt_defines.svh"

module smrt_trigger_regs
  import smrt_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  output logic            fetchReq,
  output logic      [4:0] fetchSel,
  input  wire logic       fetchValid,
  input  wire logic [7:0] fetchData,
  output logic            upValid,
  output logic      [4:0] upSel,
  output logic      [7:0] upData,
  input  wire logic       upReady,
  output logic            upstreamHalt,
  output logic            readoutBusy
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  smrt_pend_t  pendQ;
  smrt_pend_t  pendSet;
  smrt_pend_t  pendClr;
  smrt_state_e stateQ;
  smrt_state_e stateD;
  smrt_sel_t   pickSel;
  logic        pickAny;
  smrt_sel_t   curSelQ;
  smrt_pend_t  pendNext;
  logic        takeNext;
  logic        wordLoad;
  logic        haltQ;
  logic [7:0]  countQ;
  logic [7:0]  rdDataD;
  logic        wrDiag;
  logic        wrCtrl;
  logic        wrCfgA;
  logic        wrCfgB;
  logic        wrHalt;
  logic        sendDone;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  always_comb begin
    wrDiag = 1'b0;
    wrCtrl = 1'b0;
    wrCfgA = 1'b0;
    wrCfgB = 1'b0;
    wrHalt = 1'b0;
    if (!regWrEn) begin
      wrDiag = 1'b0;
    end else if (regAddr == `SMRT_ADDR_DIAG) begin
      wrDiag = 1'b1;
    end else if (regAddr == `SMRT_ADDR_CTRL) begin
      wrCtrl = 1'b1;
    end else if (regAddr == `SMRT_ADDR_CFG_A) begin
      wrCfgA = 1'b1;
    end else if (regAddr == `SMRT_ADDR_CFG_B) begin
      wrCfgB = 1'b1;
    end else if (regAddr == `SMRT_ADDR_HALT) begin
      wrHalt = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending readout requests

  // Only ones written set a request; zeros are ignored
  always_comb begin
    pendSet = '0;
    if (wrDiag) begin
      // Bit 7 ignition, 6..5 half-bridge, 4..0 output faults
      pendSet[`SMRT_SEL_BASE_DIAG +: 8] = regWrData;
    end
    if (wrCtrl) begin
      pendSet[`SMRT_SEL_BASE_CTRL +: 8] = regWrData & `SMRT_CTRL_MASK;
    end
    if (wrCfgA) begin
      // Bits 7..6 half-bridge setup, 5..0 output setup
      pendSet[`SMRT_SEL_BASE_CFG_A +: 8] = regWrData;
    end
    if (wrCfgB) begin
      // Bits 7..6 timer, 5..4 sensor, 3 operating, 2..1 comms, 0 ignition
      pendSet[`SMRT_SEL_BASE_CFG_B +: 8] = regWrData;
    end
  end

  // Highest pending request is taken while idle
  assign takeNext = (stateQ == SMRT_IDLE) && pickAny;

  // Request leaves the queue when its fetch is issued
  always_comb begin
    pendClr = '0;
    if (takeNext) begin
      pendClr[pickSel] = 1'b1;
    end
  end

  // A new request in the clearing cycle is kept
  assign pendNext = (pendQ & ~pendClr) | pendSet;

  // Pending queue
  always_ff @(posedge clock) begin
    if (rst) begin
      pendQ <= '0;
    end else begin
      pendQ <= pendNext;
    end
  end

  // Highest pending bit is served first
  smrt_priority_pick #(
    .WIDTH (32),
    .SELW  (5)
  ) u_pick (
    .reqVec (pendQ),
    .anySet (pickAny),
    .topSel (pickSel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Upstream halt command

  always_ff @(posedge clock) begin
    if (rst) begin
      haltQ <= `SMRT_HALT_RESET;
    end else if (wrHalt) begin
      haltQ <= regWrData[`SMRT_HALT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readout sequencer

  assign sendDone = upValid && upReady;

  // Fetch answer arrives while waiting
  assign wordLoad = (stateQ == SMRT_WAIT) && fetchValid;

  always_comb begin
    stateD = stateQ;
    case (stateQ)
      SMRT_IDLE: begin
        if (pickAny) begin
          stateD = SMRT_FETCH;
        end
      end
      SMRT_FETCH: begin
        stateD = SMRT_WAIT;
      end
      SMRT_WAIT: begin
        if (fetchValid) begin
          stateD = SMRT_SEND;
        end
      end
      SMRT_SEND: begin
        if (sendDone) begin
          stateD = SMRT_IDLE;
        end
      end
      default: begin
        stateD = SMRT_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      stateQ <= SMRT_IDLE;
    end else begin
      stateQ <= stateD;
    end
  end

  // Selected register latched when it leaves the queue
  always_ff @(posedge clock) begin
    if (rst) begin
      curSelQ <= '0;
    end else if (takeNext) begin
      curSelQ <= pickSel;
    end
  end

  // Fetch strobe towards the target register file
  always_ff @(posedge clock) begin
    if (rst) begin
      fetchReq <= 1'b0;
      fetchSel <= '0;
    end else begin
      fetchReq <= takeNext;
      if (takeNext) begin
        fetchSel <= pickSel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Upstream word output

  // Offer withheld while halted; word stays until accepted
  always_ff @(posedge clock) begin
    if (rst) begin
      upValid <= 1'b0;
    end else if (sendDone) begin
      upValid <= 1'b0;
    end else begin
      upValid <= (stateD == SMRT_SEND) && !haltQ;
    end
  end

  // Word captured from the fetch answer, selector from curSelQ
  always_ff @(posedge clock) begin
    if (rst) begin
      upSel  <= '0;
      upData <= '0;
    end else if (wordLoad) begin
      upSel  <= curSelQ;
      upData <= fetchData;
    end
  end

  // Status copies
  always_ff @(posedge clock) begin
    if (rst) begin
      upstreamHalt <= 1'b0;
      readoutBusy  <= 1'b0;
    end else begin
      upstreamHalt <= haltQ;
      readoutBusy  <= (stateD != SMRT_IDLE) || (pendNext != '0);
    end
  end

  // Completed readouts, wrapping
  always_ff @(posedge clock) begin
    if (rst) begin
      countQ <= '0;
    end else if (sendDone) begin
      countQ <= countQ + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Trigger registers are write-only and read as zero
  always_comb begin
    rdDataD = 8'h00;
    if (regAddr == `SMRT_ADDR_HALT) begin
      rdDataD = 8'h00;
      rdDataD[`SMRT_HALT_BIT] = haltQ;
    end else if (regAddr == `SMRT_ADDR_STATUS) begin
      rdDataD[`SMRT_STAT_BUSY]    = (stateQ != SMRT_IDLE) || pickAny;
      rdDataD[`SMRT_STAT_HALTED]  = haltQ && (stateQ == SMRT_SEND);
      rdDataD[`SMRT_STAT_SENDING] = upValid;
    end else if (regAddr == `SMRT_ADDR_PEND_HI) begin
      rdDataD = pendQ[`SMRT_SEL_BASE_DIAG +: 8];
    end else if (regAddr == `SMRT_ADDR_PEND_LO) begin
      rdDataD = pendQ[`SMRT_SEL_BASE_CFG_A +: 8];
    end else if (regAddr == `SMRT_ADDR_COUNT) begin
      rdDataD = countQ;
    end
  end

  // Data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge clock) begin
    if (rst) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      regRdData <= rdDataD;
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule

// ### hw/smrt_defines.svh
`ifndef SMRT_DEFINES_SVH
`define SMRT_DEFINES_SVH

// Register addresses
`define SMRT_ADDR_DIAG     8'h05
`define SMRT_ADDR_CTRL     8'h06
`define SMRT_ADDR_CFG_A    8'h07
`define SMRT_ADDR_CFG_B    8'h08
`define SMRT_ADDR_HALT     8'h0B
`define SMRT_ADDR_STATUS   8'h0C
`define SMRT_ADDR_PEND_HI  8'h0D
`define SMRT_ADDR_PEND_LO  8'h0E
`define SMRT_ADDR_COUNT    8'h0F

// Reset values
`define SMRT_TRIG_RESET    8'h00
`define SMRT_HALT_RESET    1'b0

// Field positions
`define SMRT_HALT_BIT      4
`define SMRT_STAT_BUSY     0
`define SMRT_STAT_HALTED   1
`define SMRT_STAT_SENDING  2
`define SMRT_CTRL_MASK     8'h0F

// Readout selector bases in the combined pending vector
`define SMRT_SEL_BASE_CFG_B  5'h00
`define SMRT_SEL_BASE_CFG_A  5'h08
`define SMRT_SEL_BASE_CTRL   5'h10
`define SMRT_SEL_BASE_DIAG   5'h18

`endif

// ### hw/smrt_pkg.sv
package smrt_pkg;

  typedef enum logic [1:0] {
    SMRT_IDLE  = 2'b00,
    SMRT_FETCH = 2'b01,
    SMRT_WAIT  = 2'b10,
    SMRT_SEND  = 2'b11
  } smrt_state_e;

  typedef logic [4:0]  smrt_sel_t;
  typedef logic [31:0] smrt_pend_t;
  typedef logic [7:0]  smrt_byte_t;

endpackage

// ### hw/smrt_priority_pick.sv
`timescale 1ns/1ps

module smrt_priority_pick #(
  parameter int WIDTH = 32,
  parameter int SELW  = 5
) (
  input  wire logic [WIDTH-1:0] reqVec,
  output logic                  anySet,
  output logic [SELW-1:0]       topSel
);

  // Highest set bit wins
  always_comb begin
    anySet = 1'b0;
    topSel = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (reqVec[i]) begin
        anySet = 1'b1;
        topSel = SELW'(i);
      end
    end
  end

endmodule

// ### bench/smrt_trigger_regs_asserts.sv
`timescale 1ns/1ps

module smrt_trigger_regs_asserts (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic       fetchReq,
  input wire logic [4:0] fetchSel,
  input wire logic       fetchValid,
  input wire logic [7:0] fetchData,
  input wire logic       upValid,
  input wire logic [4:0] upSel,
  input wire logic [7:0] upData,
  input wire logic       upReady,
  input wire logic       upstreamHalt,
  input wire logic       readoutBusy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  AST_RD_TRIG: assert property (regRdEn && regAddr inside {[8'h05:8'h08]} |=>
    regRdData == 8'h00) else $error("trigger register read not zero");
  AST_WR_START: assert property (regWrEn && regAddr inside {8'h07, 8'h08} &&
    regWrData != 8'h00 && !readoutBusy |-> ##2 fetchReq) else $error("no fetch");
  AST_WR_ZERO: assert property (regWrEn && regAddr inside {8'h07, 8'h08} &&
    regWrData == 8'h00 && !readoutBusy |=> !readoutBusy [*2]) else $error("zero busy");
  AST_FETCH_PULSE: assert property (fetchReq |=> !fetchReq)
    else $error("fetch pulse too long");
  AST_ONE_WORD: assert property (fetchReq |-> !upValid)
    else $error("fetch while word offered");
  AST_UP_DATA: assert property (fetchValid && !upstreamHalt && !upValid &&
    !$past(regWrEn && regAddr == 8'h0B) |=> upValid &&
    upData == $past(fetchData) && upSel == $past(fetchSel)) else $error("bad word");
  AST_ACCEPT: assert property (upValid && upReady |=> !upValid)
    else $error("word not dropped");
  AST_HOLD: assert property (upValid && !upReady |=> (upValid || upstreamHalt) &&
    $stable(upSel)) else $error("word lost");
  AST_HALT: assert property (upstreamHalt && $past(upstreamHalt) |-> !upValid)
    else $error("word offered while halted");
  ////////////////////////////////////////////////////////////////////////////
  cover property (upValid && upReady);
  cover property (upValid && !upReady);
  cover property (upstreamHalt && readoutBusy);
endmodule

// ### bench/smrt_far_model.sv
`timescale 1ns/1ps

module smrt_far_model (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       fetchReq,
  input wire logic [4:0] fetchSel,
  input wire logic       stall,
  output logic           fetchValid,
  output logic     [7:0] fetchData,
  output logic           upReady
);
  logic [2:0] waitQ;
  // Slow answer while stalling, prompt otherwise; data bus wiggles when idle
  always_ff @(posedge clock) begin
    if (rst) begin
      fetchValid <= 1'b0;
      fetchData  <= 8'h00;
      waitQ      <= 3'h0;
    end else begin
      fetchValid <= 1'b0;
      fetchData  <= ~fetchData;
      if (fetchReq) waitQ <= stall ? 3'h4 : 3'h1;
      else if (waitQ != 3'h0) waitQ <= waitQ - 3'h1;
      if (waitQ == 3'h1) begin
        fetchValid <= 1'b1;
        fetchData  <= 8'hC3 ^ {3'h0, fetchSel};
      end
    end
  end
  assign upReady = !stall;
endmodule

// ### bench/smrt_trigger_regs_bench.sv
`timescale 1ns/1ps
`include "smrt_defines.svh"

module smrt_trigger_regs_bench;
  logic       clock = 1'b0, rst = 1'b1, regWrEn = 1'b0, regRdEn = 1'b0;
  logic       stall = 1'b0, stallEn = 1'b0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00;
  wire  [7:0] regRdData, fetchData, upData;
  wire  [4:0] fetchSel, upSel;
  wire        fetchReq, fetchValid, upValid, upReady, upstreamHalt, readoutBusy;
  int         errors = 0, checksDone = 0, cycles = 0;
  logic [15:0] got[$];
  always #20 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  smrt_trigger_regs dut_u (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .fetchReq(fetchReq), .fetchSel(fetchSel), .fetchValid(fetchValid),
    .fetchData(fetchData), .upValid(upValid), .upSel(upSel), .upData(upData),
    .upReady(upReady), .upstreamHalt(upstreamHalt), .readoutBusy(readoutBusy));
  smrt_far_model far_u (.clock(clock), .rst(rst), .fetchReq(fetchReq),
    .fetchSel(fetchSel), .stall(stall), .fetchValid(fetchValid),
    .fetchData(fetchData), .upReady(upReady));
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    cycles++;
    stall <= stallEn & cycles[1];
    if (!rst && upValid && upReady) got.push_back({3'h0, upSel, upData});
    if (cycles == 6000) begin
      errors++;
      finish_test();
    end
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    checksDone++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrEn <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRdEn <= 1'b0;
    #1 chk({8'h00, regRdData}, {8'h00, e});
  endtask
  // Write, wait for the queue to empty, then compare words MSB first
  task drain(input logic [7:0] a, input logic [7:0] d, input logic [4:0] b, input logic [7:0] m);
    int n;
    logic [4:0] s;
    got.delete();
    wr(a, d);
    repeat (3) @(posedge clock);
    #1 n = 0;
    while (readoutBusy !== 1'b0 && n < 400) begin
      @(posedge clock);
      #1 n++;
    end
    chk({15'h0, n >= 400}, 16'h0000);
    for (int i = 7; i >= 0; i--) if (m[i]) begin
      s = b + i[4:0];
      chk(got.size() ? got.pop_front() : 16'hFFFF, {3'h0, s, 8'hC3 ^ {3'h0, s}});
    end
    chk(16'(got.size()), 16'h0000);
  endtask
  task finish_test;
    $display("Checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd(`SMRT_ADDR_CFG_A, 8'h00);
    rd(`SMRT_ADDR_CFG_B, 8'h00);
    rd(`SMRT_ADDR_DIAG, 8'h00);
    rd(8'h3F, 8'h00);
    drain(`SMRT_ADDR_DIAG, 8'hFF, `SMRT_SEL_BASE_DIAG, 8'hFF);
    drain(`SMRT_ADDR_CTRL, 8'hFF, `SMRT_SEL_BASE_CTRL, 8'h0F);
    stallEn <= 1'b1;
    drain(`SMRT_ADDR_CFG_A, 8'hFF, `SMRT_SEL_BASE_CFG_A, 8'hFF);
    drain(`SMRT_ADDR_CFG_B, 8'hFF, `SMRT_SEL_BASE_CFG_B, 8'hFF);
    stallEn <= 1'b0;
    drain(`SMRT_ADDR_CFG_A, 8'h00, `SMRT_SEL_BASE_CFG_A, 8'h00);
    drain(`SMRT_ADDR_CFG_B, 8'h81, `SMRT_SEL_BASE_CFG_B, 8'h81);
    rd(`SMRT_ADDR_STATUS, 8'h00);
    wr(`SMRT_ADDR_HALT, 8'h10);
    rd(`SMRT_ADDR_HALT, 8'h10);
    got.delete();
    wr(`SMRT_ADDR_DIAG, 8'h81);
    repeat (20) @(posedge clock);
    #1 chk({14'h0, upstreamHalt, readoutBusy}, 16'h0003);
    chk(16'(got.size()), 16'h0000);
    rd(`SMRT_ADDR_STATUS, 8'h03);
    rd(`SMRT_ADDR_PEND_HI, 8'h01);
    drain(`SMRT_ADDR_HALT, 8'h00, `SMRT_SEL_BASE_DIAG, 8'h81);
    wr(`SMRT_ADDR_HALT, 8'h10);
    wr(`SMRT_ADDR_CFG_A, 8'h24);
    repeat (20) @(posedge clock);
    rd(`SMRT_ADDR_PEND_LO, 8'h04);
    drain(`SMRT_ADDR_HALT, 8'h00, `SMRT_SEL_BASE_CFG_A, 8'h24);
    rd(`SMRT_ADDR_COUNT, 8'h22);
    finish_test();
  end
endmodule

bind smrt_trigger_regs smrt_trigger_regs_asserts chk_u (.clock(clock), .rst(rst),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .fetchReq(fetchReq), .fetchSel(fetchSel),
  .fetchValid(fetchValid), .fetchData(fetchData), .upValid(upValid), .upSel(upSel),
  .upData(upData), .upReady(upReady), .upstreamHalt(upstreamHalt),
  .readoutBusy(readoutBusy));
